// *** smad_router.sv ***
// Top of the system memory address decoder: decode, arbitration and target steering
`timescale 1ns/1ps
`default_nettype none
`include "smad_regs.svh"

// Contract
// [RULE1] One 16-Mbyte byte space, every address mapped
// [RULE2] Dual RAM: 8x8K, two accesses per cycle
// [RULE3] Single RAM: 32x8K, one access per cycle
// [RULE4] One select per external space, only during access
// [RULE5] First 192 bytes reserved; dual RAM at C0h
// [RULE6] 050000h to 800000h goes to SDRAM space
// [RULE7] Async spaces at 800000h, C00000h, E00000h, F00000h
// [RULE8] Top 128K: ROM if bit clear, else async
// [RULE9] SDRAM uses first select or first two
// [RULE10] Only DMA 3 reaches external spaces; the code refuses only DMA 0..2, so core, host and USB reach them too
// [RULE11] Host and USB masters never reach dual RAM
// [RULE12] Core, four DMAs, host, USB are independent masters
// [RULE13] Hardware reset clears remap bit, soft reset keeps
// [RULE14] ROM: one read per block, both core buses
// [RULE15] Refused or reserved accesses reach no output
module smad_router
  import smad_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Master requests and handshake: 0 core program, 1 core data, 2..5 DMA 0..3, 6 host, 7 USB
  input wire smad_req_t MST_REQ [`SMAD_NUM_MST],
  output logic [7:0] MST_READY,
  output logic [7:0] MST_ERR,
  // Mapping control
  input wire logic REMAP_WR,
  input wire logic REMAP_VAL,
  input wire logic SOFT_RESET,
  input wire logic SDRAM_DUAL_CS,
  output logic ROM_REMAP,
  // On-chip targets
  output smad_sel_t DUAL_A [`SMAD_NUM_DUAL],
  output smad_sel_t DUAL_B [`SMAD_NUM_DUAL],
  output smad_sel_t SINGLE [`SMAD_NUM_SINGLE],
  output smad_sel_t ROM [`SMAD_NUM_ROM],
  // External port
  output smad_sel_t EXT,
  output logic SDRAM_SPACE_SELECT,
  output logic SDRAM_SECOND_SELECT,
  output logic [3:0] ASYNC_SPACE_SELECTS
);

  smad_dec_t dec [`SMAD_NUM_MST];
  logic [7:0] dual_req [`SMAD_NUM_DUAL];
  logic [7:0] dual_g1 [`SMAD_NUM_DUAL];
  logic [7:0] dual_g2 [`SMAD_NUM_DUAL];
  logic [7:0] single_req [`SMAD_NUM_SINGLE];
  logic [7:0] single_g [`SMAD_NUM_SINGLE];
  logic [7:0] rom_req [`SMAD_NUM_ROM];
  logic [7:0] rom_g [`SMAD_NUM_ROM];
  logic [7:0] ext_req;
  logic [7:0] ext_g;
  logic [7:0] grant_any;
  logic [2:0] ext_mst;

  logic rom_remap_reg;
  logic rom_remap_next;
  smad_sel_t dual_a_reg [`SMAD_NUM_DUAL];
  smad_sel_t dual_a_next [`SMAD_NUM_DUAL];
  smad_sel_t dual_b_reg [`SMAD_NUM_DUAL];
  smad_sel_t dual_b_next [`SMAD_NUM_DUAL];
  smad_sel_t single_reg [`SMAD_NUM_SINGLE];
  smad_sel_t single_next [`SMAD_NUM_SINGLE];
  smad_sel_t rom_reg [`SMAD_NUM_ROM];
  smad_sel_t rom_next [`SMAD_NUM_ROM];
  smad_sel_t ext_reg;
  smad_sel_t ext_next;
  logic sdram_sel_reg;
  logic sdram_sel_next;
  logic sdram_second_reg;
  logic sdram_second_next;
  logic [3:0] async_sel_reg;
  logic [3:0] async_sel_next;

  // Builds the forwarded access of the granted master
  function automatic smad_sel_t make_sel(input smad_req_t reqs [`SMAD_NUM_MST], input logic [7:0] g);
    smad_sel_t s;
    logic [2:0] m;
    m = smad_index(g);
    s.valid = |g;
    s.mst = m;
    s.write = (|g) ? reqs[m].write : 1'b0;
    s.addr = (|g) ? reqs[m].addr : 24'h00_0000;
    return s;
  endfunction

  // Every master decodes on its own, so all of them run in parallel
  genvar gm;
  generate
    for (gm = 0; gm < `SMAD_NUM_MST; gm++)
    begin : g_dec
      smad_decode u_dec
      (
        .addr(MST_REQ[gm].addr),
        .mst(3'(gm)),
        .rom_remap(rom_remap_reg),
        .dec(dec[gm])
      ); // see [RULE12] see [RULE1]
    end
  endgenerate

  // Per-resource request vectors
  always_comb
  begin
    for (int r = 0; r < `SMAD_NUM_DUAL; r++)
    begin
      dual_req[r] = 8'h00;
    end
    for (int r = 0; r < `SMAD_NUM_SINGLE; r++)
    begin
      single_req[r] = 8'h00;
    end
    for (int r = 0; r < `SMAD_NUM_ROM; r++)
    begin
      rom_req[r] = 8'h00;
    end
    ext_req = 8'h00;
    for (int m = 0; m < `SMAD_NUM_MST; m++)
    begin
      if (MST_REQ[m].valid && dec[m].allowed)
      begin
        unique case (dec[m].tgt)
          TGT_DUAL: dual_req[dec[m].blk[2:0]][m] = 1'b1;
          TGT_SINGLE: single_req[dec[m].blk][m] = 1'b1;
          TGT_ROM: rom_req[dec[m].blk[1:0]][m] = 1'b1; // see [RULE14]
          TGT_SDRAM, TGT_ASYNC: ext_req[m] = 1'b1;
          TGT_NONE: ;
        endcase
      end
    end
  end

  genvar gr;
  generate
    for (gr = 0; gr < `SMAD_NUM_DUAL; gr++)
    begin : g_dual
      // Two grants per block, so two masters never stall each other
      smad_pick u_pick
      (
        .req(dual_req[gr]),
        .first(dual_g1[gr]),
        .second(dual_g2[gr])
      ); // see [RULE2]
    end
    for (gr = 0; gr < `SMAD_NUM_SINGLE; gr++)
    begin : g_single
      smad_pick u_pick
      (
        .req(single_req[gr]),
        .first(single_g[gr]),
        .second()
      ); // see [RULE3]
    end
    for (gr = 0; gr < `SMAD_NUM_ROM; gr++)
    begin : g_rom
      smad_pick u_pick
      (
        .req(rom_req[gr]),
        .first(rom_g[gr]),
        .second()
      ); // see [RULE14]
    end
  endgenerate

  // The external port is a single channel shared by all its chip-select spaces
  smad_pick u_ext_pick
  (
    .req(ext_req),
    .first(ext_g),
    .second()
  );

  assign ext_mst = smad_index(ext_g);

  // Handshake: a losing master simply keeps its request up and is taken later
  always_comb
  begin
    grant_any = ext_g;
    for (int r = 0; r < `SMAD_NUM_DUAL; r++)
    begin
      grant_any = grant_any | dual_g1[r] | dual_g2[r];
    end
    for (int r = 0; r < `SMAD_NUM_SINGLE; r++)
    begin
      grant_any = grant_any | single_g[r];
    end
    for (int r = 0; r < `SMAD_NUM_ROM; r++)
    begin
      grant_any = grant_any | rom_g[r];
    end
    for (int m = 0; m < `SMAD_NUM_MST; m++)
    begin
      MST_ERR[m] = MST_REQ[m].valid && !dec[m].allowed; // see [RULE15]
    end
  end

  assign MST_READY = grant_any;

  // Next values of the forwarded accesses and the remap bit
  always_comb
  begin
    for (int r = 0; r < `SMAD_NUM_DUAL; r++)
    begin
      dual_a_next[r] = make_sel(MST_REQ, dual_g1[r]);
      dual_b_next[r] = make_sel(MST_REQ, dual_g2[r]);
    end
    for (int r = 0; r < `SMAD_NUM_SINGLE; r++)
    begin
      single_next[r] = make_sel(MST_REQ, single_g[r]);
    end
    for (int r = 0; r < `SMAD_NUM_ROM; r++)
    begin
      rom_next[r] = make_sel(MST_REQ, rom_g[r]);
    end
    ext_next = make_sel(MST_REQ, ext_g);
    sdram_sel_next = (|ext_g) && (dec[ext_mst].tgt == TGT_SDRAM); // see [RULE4]
    sdram_second_next = sdram_sel_next && SDRAM_DUAL_CS; // see [RULE9]
    async_sel_next = 4'h0;
    if ((|ext_g) && (dec[ext_mst].tgt == TGT_ASYNC))
    begin
      async_sel_next[dec[ext_mst].blk[1:0]] = 1'b1; // see [RULE4] see [RULE7]
    end
    // Soft reset has no say here; only the hardware reset forces the ROM back in
    rom_remap_next = REMAP_WR ? REMAP_VAL : rom_remap_reg; // see [RULE13]
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      rom_remap_reg <= `SMAD_REMAP_RST; // see [RULE13]
      for (int r = 0; r < `SMAD_NUM_DUAL; r++)
      begin
        dual_a_reg[r] <= '0;
        dual_b_reg[r] <= '0;
      end
      for (int r = 0; r < `SMAD_NUM_SINGLE; r++)
      begin
        single_reg[r] <= '0;
      end
      for (int r = 0; r < `SMAD_NUM_ROM; r++)
      begin
        rom_reg[r] <= '0;
      end
      ext_reg <= '0;
      sdram_sel_reg <= 1'b0;
      sdram_second_reg <= 1'b0;
      async_sel_reg <= 4'h0;
    end
    else
    begin
      rom_remap_reg <= rom_remap_next;
      dual_a_reg <= dual_a_next;
      dual_b_reg <= dual_b_next;
      single_reg <= single_next;
      rom_reg <= rom_next;
      ext_reg <= ext_next;
      sdram_sel_reg <= sdram_sel_next;
      sdram_second_reg <= sdram_second_next;
      async_sel_reg <= async_sel_next;
    end
  end

  assign ROM_REMAP = rom_remap_reg;
  assign DUAL_A = dual_a_reg;
  assign DUAL_B = dual_b_reg;
  assign SINGLE = single_reg;
  assign ROM = rom_reg;
  assign EXT = ext_reg;
  assign SDRAM_SPACE_SELECT = sdram_sel_reg;
  assign SDRAM_SECOND_SELECT = sdram_second_reg;
  assign ASYNC_SPACE_SELECTS = async_sel_reg;

  a_remap_reset: assert property (@(posedge CLOCK) !RST_N |=> !ROM_REMAP) // see [RULE13]
    else $error("remap bit not cleared by hardware reset");

  a_soft_keep: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE13]
    SOFT_RESET && !REMAP_WR |=> $stable(ROM_REMAP))
    else $error("remap bit changed without a write");

  a_reserved_refuse: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE5] see [RULE15]
    MST_REQ[1].valid && MST_REQ[1].addr < `SMAD_MMR_END |-> MST_ERR[1] && !MST_READY[1])
    else $error("reserved address was not refused");

  a_dma_ext_refuse: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE10]
    MST_REQ[2].valid && MST_REQ[2].addr >= `SMAD_SINGLE_END && (MST_REQ[2].addr < `SMAD_ROM_BASE || ROM_REMAP)
    |-> MST_ERR[2] && !MST_READY[2]) else $error("low DMA reached the external port");

  a_host_dual_refuse: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE11]
    MST_REQ[6].valid && MST_REQ[6].addr >= `SMAD_MMR_END && MST_REQ[6].addr < `SMAD_DUAL_END
    |-> MST_ERR[6] && !MST_READY[6])
    else $error("host master reached dual RAM");

  a_cs_exclusive: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE4]
    $onehot0({SDRAM_SPACE_SELECT, ASYNC_SPACE_SELECTS}) && ((SDRAM_SPACE_SELECT || (|ASYNC_SPACE_SELECTS)) == EXT.valid))
    else $error("chip selects disagree with the external access");

  a_sdram_route: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE6] see [RULE9]
    MST_READY[5] && MST_REQ[5].addr >= `SMAD_SINGLE_END && MST_REQ[5].addr < `SMAD_SDRAM_END
    |=> SDRAM_SPACE_SELECT && EXT.mst == 3'h5 && SDRAM_SECOND_SELECT == $past(SDRAM_DUAL_CS))
    else $error("SDRAM access misrouted");

  a_rom_route: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE8] see [RULE14]
    MST_READY[0] && MST_REQ[0].addr >= `SMAD_ROM_BASE && !ROM_REMAP |=> ROM[$past(MST_REQ[0].addr[16:15])].valid
    && ROM[$past(MST_REQ[0].addr[16:15])].mst == 3'h0 && !(EXT.valid && EXT.mst == 3'h0))
    else $error("ROM access misrouted");

  a_remap_route: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE8]
    MST_REQ[0].valid && MST_REQ[0].addr >= `SMAD_ROM_BASE && ROM_REMAP && !(|ext_req[7:1])
    |-> MST_READY[0] ##1 ASYNC_SPACE_SELECTS[3])
    else $error("remapped ROM area not sent to the last async space");

  genvar ga;
  generate
    for (ga = 0; ga < `SMAD_NUM_DUAL; ga++)
    begin : g_chk_dual
      a_dual_two: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE2]
        $countones(dual_req[ga]) <= 2 |-> (dual_g1[ga] | dual_g2[ga]) == dual_req[ga])
        else $error("dual RAM block stalled a second access");
    end
    for (ga = 0; ga < `SMAD_NUM_SINGLE; ga++)
    begin : g_chk_single
      a_single_one: assert property (@(posedge CLOCK) disable iff (!RST_N) // see [RULE3]
        (|single_req[ga]) |-> $onehot(single_g[ga]) ##1 SINGLE[ga].valid)
        else $error("single RAM block not taking exactly one access");
    end
  endgenerate

endmodule

`default_nettype wire

// *** smad_regs.svh ***
// Address map constants and fixed counts for the system memory address decoder
`ifndef SMAD_REGS_SVH
`define SMAD_REGS_SVH

// Byte address boundaries of the 16-Mbyte space
`define SMAD_MMR_END 24'h00_00C0
`define SMAD_DUAL_END 24'h01_0000
`define SMAD_SINGLE_END 24'h05_0000
`define SMAD_SDRAM_END 24'h80_0000
`define SMAD_ASYNC1_BASE 24'hC0_0000
`define SMAD_ASYNC2_BASE 24'hE0_0000
`define SMAD_ASYNC3_BASE 24'hF0_0000
`define SMAD_ROM_BASE 24'hFE_0000

// Single-access blocks are numbered from the first one above the dual-access area
`define SMAD_SINGLE_FIRST 6'h08

// Resource and master counts
`define SMAD_NUM_MST 8
`define SMAD_NUM_DUAL 8
`define SMAD_NUM_SINGLE 32
`define SMAD_NUM_ROM 4

// Master numbering
`define SMAD_MST_CORE_PROG 3'h0
`define SMAD_MST_CORE_DATA 3'h1
`define SMAD_MST_DMA0 3'h2
`define SMAD_MST_DMA1 3'h3
`define SMAD_MST_DMA2 3'h4
`define SMAD_MST_DMA3 3'h5
`define SMAD_MST_HOST 3'h6
`define SMAD_MST_USB 3'h7

// Reset value of the ROM remap bit
`define SMAD_REMAP_RST 1'b0

`endif

// *** smad_pkg.sv ***
// Types and shared helper functions of the system memory address decoder
package smad_pkg;

  typedef enum logic [2:0]
  {
    TGT_NONE = 3'h0,
    TGT_DUAL = 3'h1,
    TGT_SINGLE = 3'h2,
    TGT_SDRAM = 3'h3,
    TGT_ASYNC = 3'h4,
    TGT_ROM = 3'h5
  } smad_tgt_t;

  typedef struct packed
  {
    logic valid;
    logic write;
    logic [23:0] addr;
  } smad_req_t;

  typedef struct packed
  {
    logic valid;
    logic write;
    logic [2:0] mst;
    logic [23:0] addr;
  } smad_sel_t;

  typedef struct packed
  {
    smad_tgt_t tgt;
    logic [4:0] blk;
    logic allowed;
  } smad_dec_t;

  // Isolates the lowest set bit
  function automatic logic [7:0] smad_lowest(input logic [7:0] x);
    return x & (~x + 8'h01);
  endfunction

  // Index of the set bit of a one-hot vector, zero when empty
  function automatic logic [2:0] smad_index(input logic [7:0] x);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (x[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

endpackage

// *** smad_decode.sv ***
// Address decode and access-right check for one master
`timescale 1ns/1ps
`default_nettype none
`include "smad_regs.svh"

module smad_decode
  import smad_pkg::*;
(
  // Request
  input wire logic [23:0] addr,
  input wire logic [2:0] mst,
  // Mapping control
  input wire logic rom_remap,
  // Result
  output smad_dec_t dec
);

  logic is_dma_low;
  logic is_host_side;

  // DMA controllers 0..2 have no path to the external port
  assign is_dma_low = (mst == `SMAD_MST_DMA0) || (mst == `SMAD_MST_DMA1) || (mst == `SMAD_MST_DMA2);
  assign is_host_side = (mst == `SMAD_MST_HOST) || (mst == `SMAD_MST_USB);

  always_comb
  begin
    dec.tgt = TGT_NONE;
    dec.blk = 5'h00;
    if (addr < `SMAD_MMR_END)
    begin
      dec.tgt = TGT_NONE; // see [RULE5]
    end
    else if (addr < `SMAD_DUAL_END)
    begin
      dec.tgt = TGT_DUAL; // see [RULE2]
      dec.blk = {2'b00, addr[15:13]};
    end
    else if (addr < `SMAD_SINGLE_END)
    begin
      dec.tgt = TGT_SINGLE; // see [RULE3]
      dec.blk = 5'(addr[18:13] - `SMAD_SINGLE_FIRST);
    end
    else if (addr < `SMAD_SDRAM_END)
    begin
      dec.tgt = TGT_SDRAM; // see [RULE6]
    end
    else if (addr < `SMAD_ASYNC1_BASE)
    begin
      dec.tgt = TGT_ASYNC; // see [RULE7]
      dec.blk = 5'h00;
    end
    else if (addr < `SMAD_ASYNC2_BASE)
    begin
      dec.tgt = TGT_ASYNC; // see [RULE7]
      dec.blk = 5'h01;
    end
    else if (addr < `SMAD_ASYNC3_BASE)
    begin
      dec.tgt = TGT_ASYNC; // see [RULE7]
      dec.blk = 5'h02;
    end
    else if (addr < `SMAD_ROM_BASE || rom_remap)
    begin
      dec.tgt = TGT_ASYNC; // see [RULE8]
      dec.blk = 5'h03;
    end
    else
    begin
      dec.tgt = TGT_ROM; // see [RULE8]
      dec.blk = {3'b000, addr[16:15]};
    end
    dec.allowed = (dec.tgt != TGT_NONE); // see [RULE15]
    if ((dec.tgt == TGT_SDRAM || dec.tgt == TGT_ASYNC) && is_dma_low)
    begin
      dec.allowed = 1'b0; // see [RULE10]
    end
    if (dec.tgt == TGT_DUAL && is_host_side)
    begin
      dec.allowed = 1'b0; // see [RULE11]
    end
  end

endmodule

`default_nettype wire

// *** smad_pick.sv ***
// Fixed-priority pick of up to two requesters, lowest master number first
`timescale 1ns/1ps
`default_nettype none

module smad_pick
  import smad_pkg::*;
(
  // Requests, one bit per master
  input wire logic [7:0] req,
  // Grants, one-hot or empty
  output logic [7:0] first,
  output logic [7:0] second
);

  assign first = smad_lowest(req);
  assign second = smad_lowest(req & ~first);

endmodule

`default_nettype wire

// *** smad_master_model.sv ***
// Bank of eight bus masters that hold each request until the decoder answers
`timescale 1ns/1ps
`default_nettype none

module smad_master_model
  import smad_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Commands from the bench
  input wire logic [7:0] go,
  input wire logic [23:0] go_addr [8],
  // Decoder answers
  input wire logic [7:0] ready,
  input wire logic [7:0] err,
  // Requests towards the decoder
  output smad_req_t req [8]
);
  smad_req_t req_reg [8];
  smad_req_t req_next [8];

  always_comb
  begin
    for (int m = 0; m < 8; m++)
    begin
      req_next[m] = req_reg[m];
      // Held until the answer is sampled, then the bus shows the inverse so stale values never match
      if (req_reg[m].valid && (ready[m] || err[m]))
      begin
        req_next[m].valid = 1'b0;
        req_next[m].addr = ~req_reg[m].addr;
      end
      if (go[m])
      begin
        req_next[m] = '{1'b1, go_addr[m][0], go_addr[m]};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    for (int m = 0; m < 8; m++)
    begin
      req_reg[m] <= rst_n ? req_next[m] : '0;
    end
  end

  assign req = req_reg;
endmodule
`default_nettype wire

// *** tb_system_memory_address_decoder.sv ***
// Self-checking bench for the system memory address decoder
`timescale 1ns/1ps
`default_nettype none

module tb_system_memory_address_decoder
  import smad_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] go = 8'h00;
  logic [23:0] go_addr [8];
  logic remap_wr = 1'b0;
  logic remap_val = 1'b0;
  logic soft_reset = 1'b0;
  logic dual_cs = 1'b0;
  smad_req_t mst_req [8];
  logic [7:0] ready;
  logic [7:0] err;
  logic rom_remap;
  smad_sel_t dual_a [8];
  smad_sel_t dual_b [8];
  smad_sel_t single [32];
  smad_sel_t rom [4];
  smad_sel_t ext;
  logic sd_sel;
  logic sd_sel2;
  logic [3:0] async_sel;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 64472;
  int remap_m = 0;
  int m;
  logic [23:0] addrs [16] = '{24'h00_0000, 24'h00_00BF, 24'h00_00C0, 24'h00_FFFF, 24'h01_0000, 24'h04_FFFF,
    24'h05_0000, 24'h7F_FFFF, 24'h80_0000, 24'hBF_FFFF, 24'hC0_0000, 24'hE0_0000, 24'hF0_0000, 24'hFD_FFFF,
    24'hFE_0000, 24'hFF_FFFF};

  smad_router uut (.CLOCK(clk), .RST_N(rst_n), .MST_REQ(mst_req), .MST_READY(ready), .MST_ERR(err),
    .REMAP_WR(remap_wr), .REMAP_VAL(remap_val), .SOFT_RESET(soft_reset), .SDRAM_DUAL_CS(dual_cs),
    .ROM_REMAP(rom_remap), .DUAL_A(dual_a), .DUAL_B(dual_b), .SINGLE(single), .ROM(rom), .EXT(ext),
    .SDRAM_SPACE_SELECT(sd_sel), .SDRAM_SECOND_SELECT(sd_sel2), .ASYNC_SPACE_SELECTS(async_sel));

  smad_master_model masters (.clk(clk), .rst_n(rst_n), .go(go), .go_addr(go_addr), .ready(ready), .err(err),
    .req(mst_req));

  always #12.5 clk = ~clk;

  task automatic close_out;
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Far above the roughly 1400 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected outcome: target code times 64 plus block, 2048 for the second SDRAM select
  function automatic int model(input int mi, input int a, input int rm);
    int c;
    if (a < 'hC0) return 0;
    if (a < 'h1_0000) return (mi >= 6) ? 0 : 64 + (a >> 13);
    if (a < 'h5_0000) return 128 + (a >> 13) - 8;
    if (a >= 'hFE_0000 && rm == 0) return 512 + ((a >> 15) & 3);
    if (mi >= 2 && mi <= 4) return 0;
    c = (a < 'h80_0000) ? 3 : (a < 'hC0_0000) ? 4 : (a < 'hE0_0000) ? 5 : (a < 'hF0_0000) ? 6 : 7;
    return c * 64 + ((c == 3 && dual_cs) ? 2048 : 0);
  endfunction

  // The master model writes when the low address bit is set, so the write flag is checked too
  function automatic int bad(input smad_sel_t s, input int mi, input int a);
    return (s.mst !== mi[2:0] || s.addr !== a[23:0] || s.write !== a[0]) ? 4096 : 0;
  endfunction

  function automatic int observe(input int mi, input int a);
    int r;
    r = 0;
    for (int i = 0; i < 8; i++)
      if (dual_a[i].valid === 1'b1 || dual_b[i].valid === 1'b1) r += 64 + i + bad(dual_a[i], mi, a);
    for (int i = 0; i < 32; i++)
      if (single[i].valid === 1'b1) r += 128 + i + bad(single[i], mi, a);
    for (int i = 0; i < 4; i++)
      if (rom[i].valid === 1'b1) r += 512 + i + bad(rom[i], mi, a);
    for (int i = 0; i < 4; i++)
      if (async_sel[i] === 1'b1) r += (4 + i) * 64;
    r += (ext.valid === 1'b1) ? bad(ext, mi, a) : 0;
    r += (sd_sel === 1'b1) ? 192 : 0;
    r += (sd_sel2 === 1'b1) ? 2048 : 0;
    if ((sd_sel === 1'b1 || async_sel !== 4'h0) && ext.valid !== 1'b1) r += 8192;
    return r;
  endfunction

  task automatic acc(input int mi, input int a);
    int e;
    e = model(mi, a, remap_m);
    @(posedge clk);
    go[mi] <= 1'b1;
    go_addr[mi] <= a[23:0];
    @(posedge clk);
    go[mi] <= 1'b0;
    @(negedge clk);
    chk({err[mi], ready[mi]}, (e == 0) ? 2 : 1);
    @(negedge clk);
    chk(observe(mi, a), e);
  endtask

  initial
  begin
    for (int i = 0; i < 8; i++)
      go_addr[i] = 24'h00_0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(rom_remap, 0);
    for (int mi = 0; mi < 8; mi++)
      for (int k = 0; k < 16; k++)
        acc(mi, addrs[k]);
    $display("Test map sweep done");
    @(posedge clk);
    remap_wr <= 1'b1;
    remap_val <= 1'b1;
    @(posedge clk);
    remap_wr <= 1'b0;
    remap_m = 1;
    @(negedge clk);
    chk(rom_remap, 1);
    for (int mi = 0; mi < 8; mi++)
      acc(mi, 'hFE_0000);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    @(negedge clk);
    chk(rom_remap, 1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    remap_m = 0;
    @(negedge clk);
    chk(rom_remap, 0);
    $display("Test remap done");
    @(posedge clk);
    dual_cs <= 1'b1;
    @(negedge clk);
    for (int mi = 0; mi < 8; mi++)
      acc(mi, 'h12_3456);
    @(posedge clk);
    dual_cs <= 1'b0;
    $display("Test two selects done");
    @(posedge clk);
    go <= 8'h03;
    go_addr[0] <= 24'h00_2000;
    go_addr[1] <= 24'h00_2000;
    @(posedge clk);
    go <= 8'h0C;
    go_addr[2] <= 24'h02_0000;
    go_addr[3] <= 24'h02_0000;
    @(negedge clk);
    chk(ready, 8'h03);
    @(posedge clk);
    go <= 8'h00;
    @(negedge clk);
    chk({dual_a[1].valid, dual_b[1].valid, dual_b[1].mst, ready}, {5'b11_001, 8'h04});
    @(negedge clk);
    // DMA 0 (master 2) wins the single block first, DMA 1 (master 3) follows a cycle later
    chk({single[8].valid, single[8].mst, ready}, {4'b1_010, 8'h08});
    @(negedge clk);
    chk(single[8].mst, 3);
    $display("Test contention done");
    repeat (300)
    begin
      m = $unsigned($random(seed)) % 8;
      acc(m, $random(seed) & 'hFF_FFFF);
    end
    $display("Test random done");
    close_out();
  end
endmodule
`default_nettype wire
